// ===== rtl/sar_readout_defs.vh
// Constants for the serial conversion-control and readout block.
// Assumes inclusion by bare name from the design files only.
`ifndef SAR_READOUT_DEFS_VH
`define SAR_READOUT_DEFS_VH

`define RESULT_W        12
`define FRAME_BITS      5'h10
`define LEAD_ZEROS      4'h4
// Count of the fourth falling edge, where the first result bit is decided and shown.
`define DATA_FIRST      5'h03
`define BIT_CNT_W       5
`define FRAME_LAST      5'h0F
`define ZERO_RESULT     12'h000
`define ST_SLEEP        2'h0
`define ST_SHIFT        2'h1
`define ST_FINISH       2'h2

`endif

// ===== rtl/edge_sync.v
// Two-stage synchroniser with edge detection for one pin input.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps

module edge_sync
(
   input  wire clk,
   input  wire reset,
   input  wire pin_in,
   output wire level,
   output wire rise,
   output wire fall
);

   reg meta_r;
   reg sync_r;
   reg prev_r;

   // The first stage feeds only the second stage, so metastability never reaches the edge logic.
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else
      begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise  = sync_r & ~prev_r;
   assign fall  = ~sync_r & prev_r;

endmodule

// ===== rtl/sar_adc_serial_readout.v
// Conversion control and serial readout of a 12-bit successive-approximation converter.
// Assumes select and serial clock arrive from a serial port master outside the clk domain,
// and that the analog comparator result arrives as a level on compare_in.
`timescale 1ns/1ps
`include "sar_readout_defs.vh"

// Function
// - Each frame carries four zero bits and then the 12-bit result, most significant bit first.
// - Every output bit after the first leading zero changes on a serial clock falling edge so the host samples it while the clock is high.
// - The result is plain unsigned binary from all zeros to all ones.
// - A select rising edge wakes the converter and starts a new conversion, and the host starts each frame so.
// - The approximation steps use only the serial clock, with no internal conversion clock.
// - A conversion lasts sixteen serial clock periods and the host supplies at least that many.
// - The serial output starts driving after the select rising edge.
// - At the frame end the output returns to high impedance after a serial clock falling edge.
// - After a conversion the converter powers down on its own.
module sar_adc_serial_readout
(
   input  wire                  clk,
   input  wire                  reset,
   input  wire                  select_in,
   input  wire                  sclk_in,
   input  wire                  compare_in,
   output reg                   serial_result_out,
   output reg                   serial_result_oe,
   output reg                   powered_up,
   output reg                   sample_hold,
   output wire [`RESULT_W-1:0]  trial_code,
   output reg  [`RESULT_W-1:0]  result_word,
   output reg                   result_valid
);

   // ****************************************
   // Input synchronisation
   // ****************************************

   wire sel_rise;
   wire sclk_fall;
   wire cmp_level;

   edge_sync sel_sync
   (
      .clk    (clk),
      .reset  (reset),
      .pin_in (select_in),
      .level  (),
      .rise   (sel_rise),
      .fall   ()
   );

   edge_sync sclk_sync
   (
      .clk    (clk),
      .reset  (reset),
      .pin_in (sclk_in),
      .level  (),
      .rise   (),
      .fall   (sclk_fall)
   );

   edge_sync cmp_sync
   (
      .clk    (clk),
      .reset  (reset),
      .pin_in (compare_in),
      .level  (cmp_level),
      .rise   (),
      .fall   ()
   );

   // ****************************************
   // Sequencer state
   // ****************************************

   reg  [1:0]              state_r;
   reg  [1:0]              state_nxt;
   reg  [`BIT_CNT_W-1:0]   bit_cnt_r;
   reg  [`BIT_CNT_W-1:0]   bit_cnt_nxt;
   reg  [`RESULT_W-1:0]    sar_r;
   reg  [`RESULT_W-1:0]    sar_nxt;
   reg  [`RESULT_W-1:0]    probe_r;
   reg  [`RESULT_W-1:0]    probe_nxt;

   // The trial code drives the capacitive DAC; probe_r marks the bit under test.
   assign trial_code = sar_r | probe_r;

   always @*
   begin
      state_nxt   = state_r;
      bit_cnt_nxt = bit_cnt_r;
      sar_nxt     = sar_r;
      probe_nxt   = probe_r;
      case (state_r)
         `ST_SLEEP:
         begin
            if (sel_rise)
            begin
               state_nxt   = `ST_SHIFT;
               bit_cnt_nxt = {`BIT_CNT_W{1'b0}};
               sar_nxt     = `ZERO_RESULT;
               probe_nxt   = {1'b1, {(`RESULT_W-1){1'b0}}};
            end
         end
         `ST_SHIFT:
         begin
            // Falling edges of the serial clock are the only conversion clock.
            if (sclk_fall)
            begin
               bit_cnt_nxt = bit_cnt_r + 1'b1;
               // The probe is empty after twelve steps, so the releasing edge changes nothing here.
               if (bit_cnt_r >= `DATA_FIRST)
               begin
                  // Keep the bit under test when the comparator says the trial is not above the input.
                  if (cmp_level)
                     sar_nxt = sar_r | probe_r;
                  probe_nxt = probe_r >> 1;
               end
               if (bit_cnt_r == `FRAME_LAST)
                  state_nxt = `ST_FINISH;
            end
         end
         `ST_FINISH:
         begin
            // Auto power-down; a new select edge is required for the next frame.
            state_nxt = `ST_SLEEP;
         end
         default:
         begin
            state_nxt = `ST_SLEEP;
         end
      endcase
   end

   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_r   <= `ST_SLEEP;
         bit_cnt_r <= {`BIT_CNT_W{1'b0}};
         sar_r     <= `ZERO_RESULT;
         probe_r   <= `ZERO_RESULT;
      end
      else
      begin
         state_r   <= state_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         sar_r     <= sar_nxt;
         probe_r   <= probe_nxt;
      end
   end

   // ****************************************
   // Serial output and power control
   // ****************************************

   // The first leading zero goes out at select, so each result bit must be shown on the
   // same falling edge that decides it; otherwise the last bit would meet the release edge.
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         serial_result_out <= 1'b0;
         serial_result_oe  <= 1'b0;
         powered_up        <= 1'b0;
         sample_hold       <= 1'b0;
         result_word       <= `ZERO_RESULT;
         result_valid      <= 1'b0;
      end
      else
      begin
         result_valid <= 1'b0;
         if (state_r == `ST_SLEEP && sel_rise)
         begin
            serial_result_oe  <= 1'b1;
            serial_result_out <= 1'b0;
            powered_up        <= 1'b1;
            sample_hold       <= 1'b1;
         end
         else if (state_r == `ST_SHIFT && sclk_fall)
         begin
            if (bit_cnt_r == `FRAME_LAST)
            begin
               // Releasing on the last falling edge keeps the LSB up for a full high phase.
               serial_result_oe  <= 1'b0;
               serial_result_out <= 1'b0;
            end
            else if (bit_cnt_r < `DATA_FIRST)
               serial_result_out <= 1'b0;
            else
               serial_result_out <= |(sar_nxt & probe_r);
         end
         else if (state_r == `ST_FINISH)
         begin
            powered_up   <= 1'b0;
            sample_hold  <= 1'b0;
            result_word  <= sar_r;
            result_valid <= 1'b1;
         end
      end
   end

endmodule

// ===== testbench/sar_readout_checker.sv
// Assertions on the ports of the serial readout block.
// Assumes the pins move only on clk edges, as the bench drives them.
`timescale 1ns/1ps
module sar_readout_checker
(
   input wire        clk,
   input wire        reset,
   input wire        select_in,
   input wire        sclk_in,
   input wire        serial_result_out,
   input wire        serial_result_oe,
   input wire        powered_up,
   input wire        sample_hold,
   input wire [11:0] result_word,
   input wire        result_valid
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   reg       sclk_d_r;
   reg [4:0] falls_r;
   // The raw pin is counted, so the count runs ahead of the block by its sync delay.
   always @(posedge clk)
   begin
      sclk_d_r <= sclk_in;
      falls_r  <= !serial_result_oe ? 5'h00 : falls_r + {4'h0, sclk_d_r & !sclk_in};
   end
   sequence s_wake; $rose(select_in) && !powered_up; endsequence
   sequence s_sleep; powered_up ##1 (!powered_up && result_valid); endsequence
   chk_released_low: assert property (!serial_result_oe |-> !serial_result_out)
      else $error("data high while released");
   chk_hold_power: assert property ((sample_hold == powered_up) && (!$rose(sample_hold) || $past(select_in, 2)))
      else $error("hold and power differ");
   chk_wake_drive: assert property (s_wake |-> ##[2:5] serial_result_oe)
      else $error("no drive after select");
   chk_start_zero: assert property ($rose(serial_result_oe) |-> $rose(powered_up) && !serial_result_out)
      else $error("bad frame start");
   chk_bit_fall: assert property ($changed(serial_result_out) |-> !$past(sclk_in, 2))
      else $error("data moved off a falling edge");
   chk_sixteen_falls: assert property ($fell(serial_result_oe) |-> falls_r == 5'h10)
      else $error("frame not sixteen clocks");
   chk_auto_sleep: assert property ($fell(serial_result_oe) |-> s_sleep)
      else $error("no power down after frame");
   chk_word_stable: assert property (!result_valid |-> $stable(result_word))
      else $error("result moved without valid");
endmodule
bind sar_adc_serial_readout sar_readout_checker i_chk (.clk, .reset, .select_in, .sclk_in, .serial_result_out,
   .serial_result_oe, .powered_up, .sample_hold, .result_word, .result_valid);

// ===== testbench/host_port_model.sv
// Host serial port and comparator model for the readout block.
// Assumes the block samples these pins with clk; sclk idles high.
`timescale 1ns/1ps
module host_port_model
(
   input  wire clk,
   input  wire serial_result_out,
   input  wire serial_result_oe,
   output reg  select_in,
   output reg  sclk_in,
   output reg  compare_in
);
   integer k;
   initial
   begin
      select_in = 1'b0;
      sclk_in = 1'b1;
      compare_in = 1'b0;
   end
   // Each bit is read just before the next fall, long after the block has settled.
   task frame(input [11:0] code, output [15:0] seen);
   begin
      @(posedge clk) select_in <= 1'b1;
      repeat (20) @(posedge clk);
      for (k = 1; k <= 16; k = k + 1)
      begin
         compare_in <= (k >= 4 && k <= 15) ? code[15-k] : 1'b0;
         repeat (4) @(posedge clk);
         seen = {seen[14:0], serial_result_oe ? serial_result_out : 1'bx};
         sclk_in <= 1'b0;
         repeat (4) @(posedge clk);
         sclk_in <= 1'b1;
      end
      select_in <= 1'b0;
   end
   endtask
endmodule

// ===== testbench/test_sar_adc_serial_readout.sv
// Self-checking bench for the serial readout block.
// Assumes the host model drives every pin of the block but clk and reset.
`timescale 1ns/1ps
module test_sar_adc_serial_readout;
   reg         clk = 1'b0;
   reg         reset = 1'b1;
   wire        select_in, sclk_in, compare_in, serial_result_out, serial_result_oe;
   wire        powered_up, sample_hold, result_valid;
   wire [11:0] trial_code, result_word;
   reg  [15:0] s;
   integer     errors = 0;
   integer     n_checks = 0;
   always #25 clk = ~clk;
   sar_adc_serial_readout i_sar_adc_serial_readout (.clk, .reset, .select_in, .sclk_in, .compare_in,
      .serial_result_out, .serial_result_oe, .powered_up, .sample_hold, .trial_code, .result_word, .result_valid);
   host_port_model host (.clk, .serial_result_out, .serial_result_oe, .select_in, .sclk_in, .compare_in);
   task check(input [8*8:1] what, input [15:0] seen, input [15:0] exp);
   begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
         errors = errors + 1;
         $display("BAD %0s expected %h seen %h", what, exp, seen);
      end
   end
   endtask
   task wrap_up;
   begin
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   task convert(input [11:0] code);
      integer i;
   begin
      host.frame(code, s);
      // Outputs are read at the falling edge, where the registered values have settled.
      @(negedge clk);
      for (i = 0; i < 12 && result_valid !== 1'b1; i = i + 1)
         @(negedge clk);
      check("valid", {15'h0000, result_valid}, 16'h0001);
      if (result_valid !== 1'b1)
         wrap_up;
      check("trial", {4'h0, trial_code}, {4'h0, code});
   end
   endtask
   task t_zero_scale;
   begin
      convert(12'h000);
      check("frame", s, 16'h0000);
      check("word", {4'h0, result_word}, 16'h0000);
      check("power", {15'h0000, powered_up}, 16'h0000);
      $display("zero scale done");
   end
   endtask
   task t_full_scale;
   begin
      convert(12'hFFF);
      check("frame", s, 16'h0FFF);
      check("word", {4'h0, result_word}, 16'h0FFF);
      $display("full scale done");
   end
   endtask
   task t_mixed_code;
   begin
      convert(12'hA5C);
      check("frame", s, 16'h0A5C);
      check("oe", {15'h0000, serial_result_oe}, 16'h0000);
      $display("mixed code done");
   end
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_zero_scale;
      repeat (160) @(posedge clk);
      t_full_scale;
      repeat (160) @(posedge clk);
      t_mixed_code;
      wrap_up;
   end
endmodule
